// >>> hdl/fetch_pipeline.sv
// two-stage fetch/execute pipeline with four-phase instruction cycle
`timescale 1ns/10ps
`include "fetch_pipe_cfg.svh"
module fetch_pipeline #(
    parameter int PC_BITS   = `PC_WIDTH,
    parameter int WORD_BITS = `WORD_WIDTH,
    parameter int DATA_BITS = `DATA_WIDTH
) (
    // oscillator_input domain
    input  wire logic                 clock,
    input  wire logic                 reset,
    // program memory
    output logic [PC_BITS-1:0]        prog_addr,
    output logic                      prog_read,
    input  wire logic [WORD_BITS-1:0] prog_word,
    // data register file
    output logic [6:0]                data_addr,
    output logic                      data_read,
    output logic                      data_write,
    input  wire logic [DATA_BITS-1:0] data_status,
    input  wire logic [DATA_BITS-1:0] data_pointer,
    // decode and alu side
    output logic [WORD_BITS-1:0]      instruction_latch,
    output logic                      exec_valid,
    output logic [3:0]                phase_out,
    input  wire logic [4:0]           operand_file,
    input  wire logic                 operand_indirect,
    input  wire logic                 dest_write,
    input  wire logic                 branch_take,
    input  wire logic [PC_BITS-1:0]   branch_target
);
    // elaboration checks: the fetch and bank paths assume these widths
    localparam int BANK_TOP = `BANK_FIELD_LSB + `BANK_FIELD_WIDTH;

    if (PC_BITS != `PC_WIDTH) begin : g_bad_pc_bits
        $error("fetch_pipeline: program counter must be ten bits");
    end
    if (WORD_BITS < 1) begin : g_bad_word_bits
        $error("fetch_pipeline: instruction word needs at least one bit");
    end
    if (DATA_BITS < 8) begin : g_bad_data_bits
        $error("fetch_pipeline: data path must be at least eight bits");
    end
    if (DATA_BITS < BANK_TOP) begin : g_bad_bank_bits
        $error("fetch_pipeline: pointer too narrow for the bank field");
    end
    if (DATA_BITS <= `PAGE_BIT_POS) begin : g_bad_page_bits
        $error("fetch_pipeline: status too narrow for the page bit");
    end
    if (`BANK_FIELD_WIDTH + `FILE_ADDR_WIDTH != 7) begin : g_bad_addr_bits
        $error("fetch_pipeline: data address must be seven bits");
    end

    typedef struct packed {
        // fetch stage
        logic [PC_BITS-1:0]   pc;
        logic [PC_BITS-1:0]   fetch_pc;
        logic [WORD_BITS-1:0] fetched;
        logic                 fetched_valid;
        // execute stage
        logic [WORD_BITS-1:0] ir;
        logic                 ir_valid;
        // memory strobes, phase view and branch flush
        logic [PC_BITS-1:0]   prog_addr;
        logic                 prog_read;
        logic [6:0]           data_addr;
        logic                 data_read;
        logic                 data_write;
        logic [3:0]           phase_out;
        logic                 flush;
    } state_t;

    state_t                 state;
    state_t                 next_state;
    fetch_pipe_pkg::phase_t phase;

    phase_generator u_phase (
        .clock (clock),
        .reset (reset),
        .phase (phase)
    );

    // page bit above 512 words, bank from pointer above 32 registers
    function automatic logic [6:0] data_address(
        input logic                 indirect,
        input logic [4:0]           file,
        input logic [DATA_BITS-1:0] ptr
    );
        logic [1:0] bank;
        logic [4:0] low;
        bank = ptr[`BANK_FIELD_LSB +: `BANK_FIELD_WIDTH];
        low  = indirect ? ptr[4:0] : file;
        data_address = {bank, low};
    endfunction

    // ten-bit counter wraps from the top word back to zero
    function automatic logic [PC_BITS-1:0] pc_step(
        input logic [PC_BITS-1:0] count
    );
        pc_step = count + PC_BITS'(1);
    endfunction

    // the code page bit stands in for the top address bit on every fetch
    function automatic logic [PC_BITS-1:0] fetch_address(
        input logic               page,
        input logic [PC_BITS-1:0] count
    );
        fetch_address = {page, count[PC_BITS-2:0]};
    endfunction

    // an empty slot executes as the no-operation word
    function automatic logic [WORD_BITS-1:0] issue_word(
        input logic                 valid,
        input logic [WORD_BITS-1:0] word
    );
        issue_word = valid ? word : WORD_BITS'(`NOP_WORD);
    endfunction

    // phase view runs one step ahead of the generator to line up with it
    function automatic logic [3:0] next_phase_code(
        input fetch_pipe_pkg::phase_t p
    );
        next_phase_code = {p[2:0], p[3]};
    endfunction

    always_comb begin
        next_state           = state;
        next_state.prog_read = 1'b0;
        next_state.data_read = 1'b0;
        next_state.data_write = 1'b0;
        next_state.phase_out = next_phase_code(phase);
        unique case (phase)
            fetch_pipe_pkg::phase_one: begin
                next_state.ir       = issue_word(state.fetched_valid,
                                                 state.fetched);
                next_state.ir_valid = state.fetched_valid & ~state.flush;
                next_state.flush    = 1'b0;
                // pc advances at start of fetch
                // ten-bit counter wraps naturally
                // the word fetched this cycle is the one the counter held,
                // so the first fetch after reset is address zero
                next_state.fetch_pc = state.pc;
                next_state.pc       = pc_step(state.pc);
            end
            fetch_pipe_pkg::phase_two: begin
                // operand read set up in phase two, strobed during phase three
                // a flushed slot reads nothing, so no file sees its operand
                next_state.data_read = state.ir_valid;
                next_state.data_addr = data_address(operand_indirect,
                                           operand_file, data_pointer);
            end
            fetch_pipe_pkg::phase_three: begin
                // present fetch address ahead of phase four
                // a full phase ahead, so the word is settled when latched
                next_state.prog_read = 1'b1;
                next_state.prog_addr = fetch_address(
                    data_status[`PAGE_BIT_POS], state.fetch_pc);
            end
            fetch_pipe_pkg::phase_four: begin
                next_state.fetched       = prog_word;
                next_state.fetched_valid = 1'b1;
                next_state.data_write    = state.ir_valid & dest_write;
                // branch costs one extra cycle
                // the word latched in this same phase is already stale
                if (state.ir_valid && branch_take) begin
                    next_state.pc    = branch_target;
                    next_state.flush = 1'b1;
                end
            end
        endcase
    end

    // pipeline empties and phase one restarts on the same edge
    always_ff @(posedge clock) begin
        if (reset) begin
            state.pc            <= `RESET_VECTOR;
            state.fetch_pc      <= `RESET_VECTOR;
            state.fetched       <= WORD_BITS'(`NOP_WORD);
            state.fetched_valid <= 1'b0;
            state.ir            <= WORD_BITS'(`NOP_WORD);
            state.ir_valid      <= 1'b0;
            state.prog_addr     <= `RESET_VECTOR;
            state.prog_read     <= 1'b0;
            state.data_addr     <= 7'h00;
            state.data_read     <= 1'b0;
            state.data_write    <= 1'b0;
            state.phase_out     <= 4'h1;
            state.flush         <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // every output is a register field; nothing combinational leaves
    assign prog_addr         = state.prog_addr;
    assign prog_read         = state.prog_read;
    assign data_addr         = state.data_addr;
    assign data_read         = state.data_read;
    assign data_write        = state.data_write;
    assign instruction_latch = state.ir;
    assign exec_valid        = state.ir_valid;
    assign phase_out         = state.phase_out;
endmodule // fetch_pipeline

// >>> hdl/fetch_pipe_cfg.svh
// timing, address and reset constants for the fetch pipeline
`ifndef FETCH_PIPE_CFG_SVH
`define FETCH_PIPE_CFG_SVH
`define PHASES_PER_CYCLE    4
`define PC_WIDTH            10
`define WORD_WIDTH          12
`define DATA_WIDTH          8
`define RESET_VECTOR        10'h000
`define PAGE_WORDS          512
`define BANK_REGS           32
`define PAGE_BIT_POS        5
`define BANK_FIELD_LSB      5
`define BANK_FIELD_WIDTH    2
`define FILE_ADDR_WIDTH     5
`define NOP_WORD            12'h000
`endif

// >>> hdl/fetch_pipe_pkg.sv
// types shared by the fetch pipeline
package fetch_pipe_pkg;
    typedef enum logic [3:0] {
        phase_one   = 4'h1,
        phase_two   = 4'h2,
        phase_three = 4'h4,
        phase_four  = 4'h8
    } phase_t;
endpackage

// >>> hdl/phase_generator.sv
// four-phase non-overlapping clock generator
`timescale 1ns/10ps
`include "fetch_pipe_cfg.svh"
module phase_generator (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   reset,
    // phase strobes
    output fetch_pipe_pkg::phase_t      phase
);
    typedef struct packed {
        fetch_pipe_pkg::phase_t phase;
    } state_t;

    state_t state;
    state_t next_state;

    always_comb begin
        next_state = state;
        unique case (state.phase)
            fetch_pipe_pkg::phase_one:   next_state.phase = fetch_pipe_pkg::phase_two;
            fetch_pipe_pkg::phase_two:   next_state.phase = fetch_pipe_pkg::phase_three;
            fetch_pipe_pkg::phase_three: next_state.phase = fetch_pipe_pkg::phase_four;
            fetch_pipe_pkg::phase_four:  next_state.phase = fetch_pipe_pkg::phase_one;
            // stray codes return to phase one
            default:                     next_state.phase = fetch_pipe_pkg::phase_one;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state.phase <= fetch_pipe_pkg::phase_one;
        end else begin
            state <= next_state;
        end
    end

    assign phase = state.phase;
endmodule // phase_generator

// >>> testbench/fetch_pipeline_sva.sv
// port assertions for the fetch pipeline
`timescale 1ns/10ps
module fetch_pipeline_sva #(
    parameter int PC_BITS = 10
) (
    // clock and reset
    input wire logic               clock,
    input wire logic               reset,
    // watched ports
    input wire logic [PC_BITS-1:0] prog_addr,
    input wire logic [7:0]         data_status,
    input wire logic               prog_read,
    input wire logic               data_read,
    input wire logic               data_write,
    input wire logic               exec_valid,
    input wire logic [3:0]         phase_out,
    input wire logic               dest_write,
    input wire logic               branch_take
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    AST_PHASE_WRAP: assert property (
        phase_out == 4'h8 |=> phase_out == 4'h1) else $error("phase wrap");
    AST_PHASE_STEP: assert property (
        phase_out != 4'h8 |=> phase_out == 4'($past(phase_out) << 1))
        else $error("phase step");
    AST_FETCH_PHASE: assert property (
        prog_read |-> phase_out == 4'h8) else $error("fetch phase");
    AST_PC_STEP: assert property (
        prog_read && !(exec_valid && branch_take) |-> ##4 prog_read
        && prog_addr[PC_BITS-2:0]
        == (PC_BITS-1)'($past(prog_addr[PC_BITS-2:0], 4) + 1))
        else $error("pc step");
    AST_CODE_PAGE: assert property (
        prog_read |-> prog_addr[PC_BITS-1] == $past(data_status[5]))
        else $error("code page");
    AST_EXEC_HOLD: assert property (
        $rose(exec_valid) |-> exec_valid[*4]) else $error("exec hold");
    AST_FLUSH: assert property (
        prog_read && exec_valid && branch_take
        |-> ##2 (!exec_valid)[*4] ##1 exec_valid) else $error("flush");
    AST_OPERAND_READ: assert property (
        data_read |-> phase_out == 4'h4 && exec_valid)
        else $error("operand read");
    AST_DEST_WRITE: assert property (
        data_write |-> $past(phase_out) == 4'h8 && $past(exec_valid)
        && $past(dest_write)) else $error("dest write");
    AST_RESET_STATE: assert property (
        $fell(reset) |-> phase_out == 4'h1 && !exec_valid)
        else $error("reset state");
endmodule // fetch_pipeline_sva

bind fetch_pipeline fetch_pipeline_sva #(.PC_BITS(PC_BITS)) chk (
    .clock(clock), .reset(reset), .prog_addr(prog_addr),
    .data_status(data_status),
    .prog_read(prog_read), .data_read(data_read), .data_write(data_write),
    .exec_valid(exec_valid), .phase_out(phase_out),
    .dest_write(dest_write), .branch_take(branch_take));

// >>> testbench/prog_memory_model.sv
// program memory model answering fetch reads
`timescale 1ns/10ps
module prog_memory_model (
    // fetch request
    input  wire logic [9:0] prog_addr,
    input  wire logic       prog_read,
    // returned word
    output logic [11:0]     prog_word
);
    // idle bus shows the inverse, so a late sample cannot match
    always_comb begin
        prog_word = prog_read ? {2'h2, prog_addr} : ~{2'h2, prog_addr};
    end
endmodule // prog_memory_model

// >>> testbench/test_quad_phase_fetch_pipeline.sv
// self-checking bench for the fetch pipeline
`timescale 1ns/10ps
module test_quad_phase_fetch_pipeline;
    logic        clock = 0, reset = 1, prog_read, data_read, data_write;
    logic        exec_valid, operand_indirect = 0, dest_write = 0;
    logic        branch_take = 0;
    logic [9:0]  prog_addr, branch_target = 10'h000;
    logic [11:0] prog_word, instruction_latch;
    logic [6:0]  data_addr;
    logic [7:0]  data_status = 8'h00;
    logic [3:0]  phase_out;
    int          fails = 0, n_tests = 0, cycles = 0;
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 400) begin
            fails++;
            summarize();
        end
    end
    fetch_pipeline dut (.clock(clock), .reset(reset), .prog_addr(prog_addr),
        .prog_read(prog_read), .prog_word(prog_word), .data_addr(data_addr),
        .data_read(data_read), .data_write(data_write),
        .data_status(data_status), .data_pointer(8'h45),
        .instruction_latch(instruction_latch), .exec_valid(exec_valid),
        .phase_out(phase_out), .operand_file(5'h0a),
        .operand_indirect(operand_indirect), .dest_write(dest_write),
        .branch_take(branch_take), .branch_target(branch_target));
    prog_memory_model mem (.prog_addr(prog_addr), .prog_read(prog_read),
        .prog_word(prog_word));
    task automatic check(string what, logic [11:0] exp, logic [11:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // sel 0 fetch strobe, 1 operand read, 2 destination write
    task automatic wait_for(int sel);
        int n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (n < 16 && !(sel == 0 ? prog_read === 1'b1 :
            sel == 1 ? data_read === 1'b1 : data_write === 1'b1));
        if (n == 16) check("wait", 12'h001, 12'h000);
    endtask
    task automatic reset_start();
        check("phase", 12'h001, {8'h0, phase_out});
        check("valid", 12'h000, {11'h0, exec_valid});
        wait_for(0);
        check("first addr", 12'h000, {2'h0, prog_addr});
        repeat (2) @(posedge clock);
        #1;
        check("ir", 12'h800, instruction_latch);
    endtask
    task automatic stream();
        logic [9:0] a;
        wait_for(0);
        a = prog_addr;
        for (int i = 0; i < 3; i++) begin
            repeat (4) @(posedge clock);
            #1;
            check("fetch", 12'h001, {11'h0, prog_read});
            check("addr", {2'h0, a + 10'h1}, {2'h0, prog_addr});
            a = prog_addr;
        end
    endtask
    task automatic data_path();
        for (int k = 0; k < 2; k++) begin
            @(posedge clock);
            operand_indirect <= k[0];
            dest_write <= 1'b1;
            repeat (2) wait_for(1);
            check("bank", k ? 12'h045 : 12'h04a, {5'h0, data_addr});
            wait_for(2);
            check("write phase", 12'h001, {8'h0, phase_out});
        end
        @(posedge clock);
        dest_write <= 1'b0;
    endtask
    task automatic branch_wrap();
        wait_for(0);
        @(posedge clock);
        branch_take <= 1'b1;
        branch_target <= 10'h3fe;
        data_status <= 8'h20;
        wait_for(0);
        @(posedge clock);
        branch_take <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            wait_for(0);
            if (i == 0) check("flush", 12'h000, {11'h0, exec_valid});
            check("target", {3'h5, 9'(9'h1fe + i)}, prog_word);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        #1;
        reset_start();
        stream();
        data_path();
        branch_wrap();
        summarize();
    end
endmodule // test_quad_phase_fetch_pipeline
